// *** design/clock_synth_regs.vh ***
// Register map, field positions, reset values and timing for the clock synth unit
`ifndef CLOCK_SYNTH_REGS_VH
`define CLOCK_SYNTH_REGS_VH

// ==========================================================
// Register addresses (processor address space)
`define PLL_SETUP_CONFIG_ADDR 16'ha034
`define PLL_STATE_REGISTER_ADDR 16'ha035
`define OUT_SELECT_CONFIG_ADDR 16'ha03d

// ==========================================================
// pll_setup_config fields
`define CFG_SEL_LSB 0
`define CFG_SEL_MSB 2
`define CFG_SSC_WIDE_BIT 4
`define CFG_SSC_EN_BIT 5
`define CFG_SYS_EN_BIT 6
`define CFG_USB_EN_BIT 7
`define PLL_SETUP_CONFIG_RST 8'hc0

// Select codes
`define SEL_OFF_A 3'h0
`define SEL_26M_A 3'h1
`define SEL_XTAL32K 3'h2
`define SEL_26M_B 3'h3
`define SEL_OFF_B 3'h4
`define SEL_12M 3'h5
`define SEL_13M 3'h6
`define SEL_19M2 3'h7

// Reference rate codes driven to the analog PLL
`define RATE_26M 2'h0
`define RATE_12M 2'h1
`define RATE_13M 2'h2
`define RATE_19M2 2'h3

// ==========================================================
// pll_state_register fields
`define ST_LOCK_BIT 0
`define ST_OSC_A_EN_BIT 1
`define ST_OSC_B_EN_BIT 2
`define ST_SLOW_A_EN_BIT 4
`define ST_SLOW_B_EN_BIT 5
`define ST_STABLE_BIT 6
`define ST_WRITE_MASK 8'h3e
`define PLL_STATE_REGISTER_RST 8'h00

// ==========================================================
// out_select_config fields
`define OS_PIN_MODE_BIT 0
`define OS_USB_24M_BIT 1
`define OS_SYS_REF_BIT 2
`define OS_OSC_B_LSB 3
`define OS_OSC_B_MSB 4
`define OS_OSC_A_LSB 5
`define OS_OSC_A_MSB 6
`define OS_LOW_VOLT_BIT 7
`define OUT_SELECT_CONFIG_RST 8'h01

// ==========================================================
// Timing
`define CLK_MHZ 100
`define PLL_SETTLE_US 3000
// Cycles after sys_rst before a supply edge counts: synchroniser depth plus one
`define POR_ARM_CYC 2'h3

`endif

// *** design/sync_two_flop.v ***
// Two-flop synchroniser, one chain per bit
`default_nettype none

module sync_two_flop #(
    parameter WIDTH = 8
) (
    input wire core_clk,
    input wire sys_rst,
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);
    // ==========================================================
    // Per-bit chains; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : chain
            reg stage1_reg;
            reg stage2_reg;
            // Metastability settles in stage one
            always @(posedge core_clk) begin
                if (sys_rst) begin
                    stage1_reg <= 1'b0;
                    stage2_reg <= 1'b0;
                end else begin
                    stage1_reg <= asyncIn[i];
                    stage2_reg <= stage1_reg;
                end
            end
            assign syncOut[i] = stage2_reg;
        end
    endgenerate
endmodule // sync_two_flop

`default_nettype wire

// *** design/clock_synth_unit.v ***
// Control logic of the clock synth unit: PLL select, output routing, registers
`default_nettype none
`include "clock_synth_regs.vh"

module clock_synth_unit #(
    parameter PLL_SETTLE_CYC = `PLL_SETTLE_US * `CLK_MHZ
) (
    input wire core_clk,
    input wire sys_rst,
    input wire [15:0] regAddr,
    input wire regWrEn,
    input wire [7:0] regWrData,
    input wire regRdEn,
    output wire [7:0] regRdData,
    input wire refOscInput,
    input wire slowClockIn,
    input wire pllClk12,
    input wire pllClk24,
    input wire pllClk48,
    input wire pllLockIn,
    input wire slowStableIn,
    input wire systemSupplyGood,
    output wire pllPowerUp,
    output wire pllRefCrystal,
    output wire [1:0] pllRefRate,
    output wire sscEnable,
    output wire sscWide,
    output wire oscDriveLowVolt,
    output wire oscOutA,
    output wire oscOutAOeN,
    output wire oscOutB,
    output wire oscOutBOeN,
    output wire systemClockPin,
    output wire usbClockPin,
    output wire slowClockOutA,
    output wire slowClockOutAOeN,
    output wire slowClockOutB
);
    // ==========================================================
    // Input synchronisers
    // Pin clocks are sampled at 100 MHz; faster sources alias, so the
    // routed copies here are a control model, not a jitter-free path.
    wire [7:0] syncIn;
    wire refS = syncIn[0];
    wire slowS = syncIn[1];
    wire p12S = syncIn[2];
    wire p24S = syncIn[3];
    wire p48S = syncIn[4];
    wire lockS = syncIn[5];
    wire stableS = syncIn[6];
    wire supplyS = syncIn[7];

    sync_two_flop #(.WIDTH(8)) inSync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .asyncIn({systemSupplyGood, slowStableIn, pllLockIn, pllClk48, pllClk24,
                  pllClk12, slowClockIn, refOscInput}),
        .syncOut(syncIn)
    );

    // ==========================================================
    // Power-on reset from supply rising edge
    reg supplyPrev_reg; // Last sampled supply level
    reg porPulse_reg; // One-cycle reset pulse
    reg [1:0] porArm_reg; // Counts out the synchroniser fill after sys_rst
    wire porArmed = (porArm_reg == `POR_ARM_CYC);
    wire logicRst = sys_rst | porPulse_reg;

    // The synchroniser restarts at 0, so the rise it shows while filling is
    // not a real supply edge; a true rise in that window is covered by sys_rst.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            supplyPrev_reg <= 1'b0;
            porPulse_reg <= 1'b0;
            porArm_reg <= 2'h0;
        end else begin
            supplyPrev_reg <= supplyS;
            if (!porArmed) begin
                // Still filling the synchroniser
                porArm_reg <= porArm_reg + 2'h1;
            end
            porPulse_reg <= supplyS & ~supplyPrev_reg & porArmed;
        end
    end

    // ==========================================================
    // Configuration registers
    reg [7:0] pllCfg_reg; // pll_setup_config
    reg [7:0] stateCtl_reg; // Writable bits of pll_state_register
    reg [7:0] outSel_reg; // out_select_config
    reg [7:0] rdData_reg; // Read return, one cycle after strobe
    wire [7:0] stateRead = {1'b0, stableS, stateCtl_reg[5:1], lockS};

    // Writes land on the clock edge of the strobe
    always @(posedge core_clk) begin
        if (logicRst) begin
            pllCfg_reg <= `PLL_SETUP_CONFIG_RST;
            stateCtl_reg <= `PLL_STATE_REGISTER_RST;
            outSel_reg <= `OUT_SELECT_CONFIG_RST;
        end else if (regWrEn) begin
            case (regAddr)
                `PLL_SETUP_CONFIG_ADDR: begin
                    pllCfg_reg <= regWrData;
                end
                `PLL_STATE_REGISTER_ADDR: begin
                    // Lock, stable and bit 7 are read-only
                    stateCtl_reg <= regWrData & `ST_WRITE_MASK;
                end
                `OUT_SELECT_CONFIG_ADDR: begin
                    outSel_reg <= regWrData;
                end
                default: begin
                    // Unmapped writes are ignored
                end
            endcase
        end
    end

    // Read mux, unmapped reads return zero
    always @(posedge core_clk) begin
        if (logicRst) begin
            rdData_reg <= 8'h00;
        end else if (regRdEn) begin
            case (regAddr)
                `PLL_SETUP_CONFIG_ADDR: rdData_reg <= pllCfg_reg;
                `PLL_STATE_REGISTER_ADDR: rdData_reg <= stateRead;
                `OUT_SELECT_CONFIG_ADDR: rdData_reg <= outSel_reg;
                default: rdData_reg <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // PLL code decode
    wire [2:0] selCode = pllCfg_reg[`CFG_SEL_MSB:`CFG_SEL_LSB];
    reg codeOn; // PLL should be powered
    reg codeXtal; // Reference is the 32 kHz crystal
    reg [1:0] codeRate; // Oscillator reference rate

    always @* begin
        codeOn = 1'b1;
        codeXtal = 1'b0;
        codeRate = `RATE_26M;
        case (selCode)
            `SEL_OFF_A, `SEL_OFF_B: codeOn = 1'b0;
            `SEL_26M_A, `SEL_26M_B: codeRate = `RATE_26M;
            `SEL_XTAL32K: codeXtal = 1'b1;
            `SEL_12M: codeRate = `RATE_12M;
            `SEL_13M: codeRate = `RATE_13M;
            `SEL_19M2: codeRate = `RATE_19M2;
            default: codeOn = 1'b0;
        endcase
    end

    // ==========================================================
    // Settle timer: any code change restarts it
    // Relies on software choosing the right code first; the timer only
    // masks glitches, it cannot detect a mismatched reference.
    reg [2:0] codeApplied_reg; // Code last handed to the PLL
    reg [18:0] settleCnt_reg; // Cycles left before PLL clocks pass
    reg pllOn_reg;
    reg pllXtal_reg;
    reg [1:0] pllRate_reg;
    wire settled = (settleCnt_reg == 19'h00000);
    // outputs only after settle and lock
    wire pllGood = pllOn_reg & settled & lockS;

    always @(posedge core_clk) begin
        if (logicRst) begin
            codeApplied_reg <= `SEL_OFF_A;
            settleCnt_reg <= 19'h00000;
            pllOn_reg <= 1'b0;
            pllXtal_reg <= 1'b0;
            pllRate_reg <= `RATE_26M;
        end else begin
            codeApplied_reg <= selCode;
            pllOn_reg <= codeOn;
            pllXtal_reg <= codeXtal;
            pllRate_reg <= codeRate;
            if (selCode != codeApplied_reg) begin
                settleCnt_reg <= PLL_SETTLE_CYC[18:0];
            end else if (!settled) begin
                settleCnt_reg <= settleCnt_reg - 19'h00001;
            end
        end
    end

    // ==========================================================
    // Output routing, every pin from a flip-flop
    reg oscA_reg, oscAOeN_reg, oscB_reg, oscBOeN_reg;
    reg sys_reg, usb_reg, slowA_reg, slowAOeN_reg, slowB_reg;
    // PLL-derived sources held low unless good
    wire g12 = p12S & pllGood;
    wire g24 = p24S & pllGood;
    wire g48 = p48S & pllGood;
    wire [1:0] selA = outSel_reg[`OS_OSC_A_MSB:`OS_OSC_A_LSB];
    wire [1:0] selB = outSel_reg[`OS_OSC_B_MSB:`OS_OSC_B_LSB];

    always @(posedge core_clk) begin
        if (logicRst) begin
            oscA_reg <= 1'b0;
            oscAOeN_reg <= 1'b1;
            oscB_reg <= 1'b0;
            oscBOeN_reg <= 1'b1;
            sys_reg <= 1'b0;
            usb_reg <= 1'b0;
            slowA_reg <= 1'b0;
            slowAOeN_reg <= 1'b1;
            slowB_reg <= 1'b0;
        end else begin
            oscA_reg <= stateCtl_reg[`ST_OSC_A_EN_BIT] &
                        (selA[1] ? g24 : (selA[0] ? slowS : refS));
            // Pin is shared with the fast crystal input
            oscAOeN_reg <= ~(outSel_reg[`OS_PIN_MODE_BIT] & stateCtl_reg[`ST_OSC_A_EN_BIT]);
            oscB_reg <= stateCtl_reg[`ST_OSC_B_EN_BIT] &
                        (selB[1] ? g48 : (selB[0] ? g12 : refS));
            oscBOeN_reg <= ~stateCtl_reg[`ST_OSC_B_EN_BIT];
            // system clock source, enable bit 6
            sys_reg <= pllCfg_reg[`CFG_SYS_EN_BIT] &
                       (outSel_reg[`OS_SYS_REF_BIT] ? refS : g12);
            usb_reg <= pllCfg_reg[`CFG_USB_EN_BIT] &
                       (outSel_reg[`OS_USB_24M_BIT] ? g24 : g48);
            // crystal-output pin driven only when bit 4
            slowA_reg <= stateCtl_reg[`ST_SLOW_A_EN_BIT] & slowS;
            slowAOeN_reg <= ~stateCtl_reg[`ST_SLOW_A_EN_BIT];
            slowB_reg <= stateCtl_reg[`ST_SLOW_B_EN_BIT] & slowS;
        end
    end

    // ==========================================================
    // Port drivers
    assign regRdData = rdData_reg;
    assign pllPowerUp = pllOn_reg;
    assign pllRefCrystal = pllXtal_reg;
    assign pllRefRate = pllRate_reg;
    assign sscEnable = pllCfg_reg[`CFG_SSC_EN_BIT];
    assign sscWide = pllCfg_reg[`CFG_SSC_WIDE_BIT];
    assign oscDriveLowVolt = outSel_reg[`OS_LOW_VOLT_BIT];
    assign oscOutA = oscA_reg;
    assign oscOutAOeN = oscAOeN_reg;
    assign oscOutB = oscB_reg;
    assign oscOutBOeN = oscBOeN_reg;
    assign systemClockPin = sys_reg;
    assign usbClockPin = usb_reg;
    assign slowClockOutA = slowA_reg;
    assign slowClockOutAOeN = slowAOeN_reg;
    assign slowClockOutB = slowB_reg;
endmodule // clock_synth_unit

`default_nettype wire

// *** dv/clock_synth_unit_chk.sv ***
// Port-level assertions for the clock synth unit
`default_nettype none
module clock_synth_unit_chk (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [15:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic pllPowerUp,
    input wire logic pllRefCrystal,
    input wire logic [1:0] pllRefRate,
    input wire logic usbClockPin
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ========================================
    // Write decode of the setup register
    wire logic cfgWr = regWrEn && regAddr == 16'ha034;
    // ========================================
    // PLL power and reference, two edges after the write
    pll_off_a: assert property (cfgWr && regWrData[1:0] == 2'h0 |-> ##2 !pllPowerUp)
        else $error("PLL powered for an off code");
    pll_on_a: assert property (cfgWr && regWrData[1:0] != 2'h0 |-> ##2 pllPowerUp)
        else $error("PLL not powered for an on code");
    ref_crystal_a: assert property (cfgWr && regWrData[2:0] == 3'h2 |-> ##2 pllRefCrystal)
        else $error("crystal reference not chosen");
    ref_rate_a: assert property (cfgWr && regWrData[2] && regWrData[1:0] != 2'h0
        |-> ##2 pllRefRate == $past(regWrData[1:0], 2) && !pllRefCrystal)
        else $error("wrong reference rate for fast codes");
    rate_26m_a: assert property (cfgWr && !regWrData[2] && regWrData[0]
        |-> ##2 pllRefRate == 2'h0 && !pllRefCrystal)
        else $error("wrong reference for 26 MHz codes");
    // ========================================
    // Output gating; the one-flop pipeline lag needs two idle cycles, five are used
    pll_static_a: assert property (!pllPowerUp [*5] |-> !usbClockPin)
        else $error("USB pin toggles with PLL off");
    usb_disable_a: assert property (cfgWr && !regWrData[7] ##1 !regWrEn [*4] |-> !usbClockPin)
        else $error("USB pin active while disabled");
    unmapped_read_a: assert property (regRdEn && regAddr != 16'ha034 && regAddr != 16'ha035
        && regAddr != 16'ha03d |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
endmodule // clock_synth_unit_chk

bind clock_synth_unit clock_synth_unit_chk chk (.core_clk, .sys_rst, .regAddr, .regWrEn,
    .regWrData, .regRdEn, .regRdData, .pllPowerUp, .pllRefCrystal, .pllRefRate, .usbClockPin);
`default_nettype wire

// *** dv/pll_model.sv ***
// Behavioural analog PLL: lock delay and three derived clocks
`default_nettype none
module pll_model (
    input wire logic pllPowerUp,
    output var logic pllClk12,
    output var logic pllClk24,
    output var logic pllClk48,
    output var logic pllLockIn
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pllLockIn = 0;
    end
    // Clocks stand still at 0 while unpowered, as a real PLL gives nothing
    initial pllClk12 = 0;
    initial pllClk24 = 0;
    initial pllClk48 = 0;
    always #41.667 pllClk12 = pllPowerUp & ~pllClk12;
    always #20.833 pllClk24 = pllPowerUp & ~pllClk24;
    always #10.417 pllClk48 = pllPowerUp & ~pllClk48;
    // Lock after 200 ns of power, lost at once on power down
    always @(posedge pllPowerUp) #200 pllLockIn = pllPowerUp;
    always @(negedge pllPowerUp) pllLockIn = 0;
endmodule // pll_model
`default_nettype wire

// *** dv/clock_synth_unit_test.sv ***
// Self-checking bench for the clock synth unit
`default_nettype none
module clock_synth_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, sys_rst = 1, regWrEn = 0, regRdEn = 0;
    logic refOscInput = 0, slowClockIn = 0, slowStableIn = 0, systemSupplyGood = 0;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0] regWrData = 8'h00;
    wire logic [7:0] regRdData;
    wire logic [1:0] pllRefRate;
    wire logic pllPowerUp, pllRefCrystal, oscOutA, oscOutAOeN, oscOutB, systemClockPin;
    wire logic usbClockPin, slowClockOutA, slowClockOutAOeN, slowClockOutB;
    wire logic pllClk12, pllClk24, pllClk48, pllLockIn;
    wire logic sscEnable, sscWide, oscDriveLowVolt, oscOutBOeN;
    int nMismatch = 0, checks = 0, cyc = 0;
    // Short settle count keeps each code change quick
    clock_synth_unit #(.PLL_SETTLE_CYC(20)) dut (.core_clk, .sys_rst, .regAddr, .regWrEn,
        .regWrData, .regRdEn, .regRdData, .refOscInput, .slowClockIn, .pllClk12, .pllClk24,
        .pllClk48, .pllLockIn, .slowStableIn, .systemSupplyGood, .pllPowerUp, .pllRefCrystal,
        .pllRefRate, .sscEnable, .sscWide, .oscDriveLowVolt, .oscOutA, .oscOutAOeN,
        .oscOutB, .oscOutBOeN, .systemClockPin, .usbClockPin, .slowClockOutA,
        .slowClockOutAOeN, .slowClockOutB);
    pll_model pll (.pllPowerUp, .pllClk12, .pllClk24, .pllClk48, .pllLockIn);
    always #5 core_clk = ~core_clk;
    // ========================================
    // Hang guard, far above the few thousand cycles needed
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            nMismatch++;
            test_done();
        end
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, nMismatch);
        if (nMismatch == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // ========================================
    // Register strobes, one cycle each, set at the falling edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1;
        @(negedge core_clk);
        regWrEn = 0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge core_clk);
        regAddr = a;
        regRdEn = 1;
        @(negedge core_clk);
        regRdEn = 0;
        d = regRdData;
    endtask
    function automatic logic pick(input int w);
        case (w)
            0: return usbClockPin;
            1: return systemClockPin;
            2: return oscOutA;
            default: return oscOutB;
        endcase
    endfunction
    // Edge count over 100 cycles, sorted into static, 12, 24 or 48 MHz
    task automatic togs(input int w, output logic [7:0] c);
        logic p;
        logic s;
        int n;
        // Let a just-written setting pass the sync and output flops first
        repeat (4) @(negedge core_clk);
        n = 0;
        p = pick(w);
        repeat (100) begin
            @(negedge core_clk);
            s = pick(w);
            n += int'(s !== p);
            p = s;
        end
        c = n == 0 ? 8'h00 : n < 36 ? 8'h0c : n < 65 ? 8'h18 : 8'h30;
    endtask
    // ========================================
    // Scenarios
    task automatic t_reset;
        logic [7:0] d;
        rd(16'ha034, d);
        chk("setup reset", d, 8'hc0);
        rd(16'ha03d, d);
        chk("select reset", d, 8'h01);
        chk("ssc reset", {6'h0, sscEnable, sscWide}, 8'h00);
        chk("low volt reset", {7'h0, oscDriveLowVolt}, 8'h00);
        wr(16'ha035, 8'hff);
        rd(16'ha035, d);
        chk("state writable", d, 8'h3e);
        rd(16'h1234, d);
        chk("unmapped read", d, 8'h00);
        $display("reset test done");
    endtask
    task automatic t_codes;
        logic [7:0] d;
        for (int c = 0; c < 8; c++) begin
            wr(16'ha034, 8'hc0 | 8'(c));
            repeat (2) @(negedge core_clk);
            chk("power", {7'h0, pllPowerUp}, 8'(c[1:0] != 2'h0));
            chk("crystal", {7'h0, pllRefCrystal}, 8'(c == 2));
            if (c != 2) chk("rate", {6'h0, pllRefRate}, c[2] ? 8'(c[1:0]) : 8'h00);
            repeat (50) @(negedge core_clk);
            togs(0, d);
            chk("usb activity", d, c[1:0] != 2'h0 ? 8'h30 : 8'h00);
        end
        $display("code test done");
    endtask
    task automatic t_usb;
        logic [7:0] d;
        wr(16'ha03d, 8'h03);
        togs(0, d);
        chk("usb 24M", d, 8'h18);
        togs(1, d);
        chk("sys 12M", d, 8'h0c);
        wr(16'ha03d, 8'h05);
        refOscInput = 1;
        togs(0, d);
        chk("usb 48M", d, 8'h30);
        chk("sys ref", {7'h0, systemClockPin}, 8'h01);
        wr(16'ha034, 8'h77);
        togs(0, d);
        chk("usb off", d, 8'h00);
        chk("ssc set", {6'h0, sscEnable, sscWide}, 8'h03);
        chk("sys on", {7'h0, systemClockPin}, 8'h01);
        wr(16'ha034, 8'h87);
        togs(0, d);
        chk("usb on", d, 8'h30);
        chk("sys off", {7'h0, systemClockPin}, 8'h00);
        chk("ssc clear", {6'h0, sscEnable, sscWide}, 8'h00);
        $display("usb test done");
    endtask
    task automatic t_route;
        logic [7:0] d;
        for (int i = 0; i < 4; i++) begin
            refOscInput = i[0];
            slowClockIn = i[1];
            wr(16'ha03d, 8'h01);
            repeat (5) @(negedge core_clk);
            chk("osc A ref", {7'h0, oscOutA}, 8'(i[0]));
            chk("osc B ref", {7'h0, oscOutB}, 8'(i[0]));
            wr(16'ha03d, 8'h21);
            repeat (5) @(negedge core_clk);
            chk("osc A slow", {7'h0, oscOutA}, 8'(i[1]));
            chk("slow out A", {7'h0, slowClockOutA}, 8'(i[1]));
            chk("slow out B", {7'h0, slowClockOutB}, 8'(i[1]));
        end
        chk("slow A driven", {7'h0, slowClockOutAOeN}, 8'h00);
        chk("osc B driven", {7'h0, oscOutBOeN}, 8'h00);
        wr(16'ha03d, 8'h49);
        togs(2, d);
        chk("osc A 24M", d, 8'h18);
        togs(3, d);
        chk("osc B 12M", d, 8'h0c);
        wr(16'ha03d, 8'hd1);
        togs(3, d);
        chk("osc B 48M", d, 8'h30);
        chk("low volt drive", {7'h0, oscDriveLowVolt}, 8'h01);
        wr(16'ha035, 8'h00);
        repeat (5) @(negedge core_clk);
        chk("slow A released", {7'h0, slowClockOutAOeN}, 8'h01);
        chk("osc A released", {7'h0, oscOutAOeN}, 8'h01);
        chk("osc B released", {7'h0, oscOutBOeN}, 8'h01);
        $display("route test done");
    endtask
    task automatic t_por;
        logic [7:0] d;
        wr(16'ha034, 8'h07);
        slowStableIn = 1;
        systemSupplyGood = 0;
        repeat (5) @(negedge core_clk);
        systemSupplyGood = 1;
        repeat (8) @(negedge core_clk);
        rd(16'ha034, d);
        chk("setup after supply", d, 8'hc0);
        rd(16'ha035, d);
        chk("state after supply", d, 8'h40);
        $display("supply test done");
    endtask
    initial begin
        repeat (4) @(negedge core_clk);
        systemSupplyGood = 1;
        repeat (12) @(negedge core_clk);
        sys_rst = 0;
        t_reset();
        t_codes();
        t_usb();
        t_route();
        t_por();
        test_done();
    end
endmodule // clock_synth_unit_test
`default_nettype wire
